// [rtl/aotu_pkg.sv]
package aotu_pkg;

  // channel counts
  localparam int NUM_DO  = 5;
  localparam int NUM_RLY = 4;
  localparam int NUM_CH  = NUM_DO + NUM_RLY;
  localparam int NUM_DI  = 5;
  localparam int NUM_INV = 8;

  // timing: clock rate and the one-second delay unit
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_S = 1;
  localparam int NS_PER_S      = 1_000_000_000;
  localparam int TICK_CYCLES   = (NS_PER_S / CLK_PERIOD_NS) * TICK_PERIOD_S;

  // source selection
  localparam logic [2:0] SRC_ALARM   = 3'h0;
  localparam logic [2:0] SRC_INV     = 3'h1;
  localparam logic [2:0] SRC_DI_BASE = 3'h2;
  localparam logic [2:0] SRC_DI_LAST = 3'h6;

  // trigger selection, meaning depends on source
  localparam logic [2:0] TRG_ANY     = 3'h0;
  localparam logic [2:0] TRG_OVP     = 3'h1;
  localparam logic [2:0] TRG_OTP     = 3'h2;
  localparam logic [2:0] TRG_OLP     = 3'h3;
  localparam logic [2:0] TRG_SCP     = 3'h4;
  localparam logic [2:0] TRG_INV_ON  = 3'h0;
  localparam logic [2:0] TRG_INV_OFF = 3'h1;
  localparam logic [2:0] TRG_DI_HIGH = 3'h0;
  localparam logic [2:0] TRG_DI_LOW  = 3'h1;

  // delay codes and their length in seconds
  localparam logic [3:0] DLY_IMMED  = 4'h0;
  localparam logic [3:0] DLY_1S     = 4'h1;
  localparam logic [3:0] DLY_5S     = 4'h2;
  localparam logic [3:0] DLY_10S    = 4'h3;
  localparam logic [3:0] DLY_30S    = 4'h4;
  localparam logic [3:0] DLY_1MIN   = 4'h5;
  localparam logic [3:0] DLY_10MIN  = 4'hE;
  localparam logic [9:0] SEC_1      = 10'h001;
  localparam logic [9:0] SEC_5      = 10'h005;
  localparam logic [9:0] SEC_10     = 10'h00A;
  localparam logic [9:0] SEC_30     = 10'h01E;
  localparam logic [9:0] SEC_PER_MIN = 10'h03C;

  // register byte offsets
  localparam logic [7:0] ADDR_CFG_BASE   = 8'h00;
  localparam logic [7:0] ADDR_OUT_STATE  = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h2C;
  localparam logic [7:0] ADDR_DI_LEVEL   = 8'h30;

  // configuration word field positions
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_TRG_LSB = 4;
  localparam int CFG_LVL_BIT = 8;
  localparam int CFG_DLY_LSB = 12;

  // reset values
  localparam logic [2:0] RST_SOURCE   = SRC_ALARM;
  localparam logic [2:0] RST_TRIGGER  = TRG_ANY;
  localparam logic       RST_LEVEL    = 1'b1;
  localparam logic [3:0] RST_DELAY    = DLY_IMMED;
  localparam logic [8:0] RST_IRQ_MASK = 9'h000;
  localparam logic       RST_DI_LEVEL = 1'b1;

  typedef struct packed {
    logic [2:0] source;
    logic [2:0] trigger;
    logic       active_high;
    logic [3:0] delay;
  } aotu_cfg_t;

  typedef struct packed {
    logic connected;
    logic running;
    logic remote_off;
    logic alarm;
    logic over_voltage_protection;
    logic over_temperature_protection;
    logic overload_protection;
    logic short_circuit_protection;
    logic other_protection;
  } aotu_inv_report_t;

endpackage

// [rtl/aotu_delay_chan.sv]
module aotu_delay_chan #(
  parameter int TICK_CYCLES = aotu_pkg::TICK_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       cond_in,
  input  wire logic [9:0] delay_sec_in,
  output logic            asserted_out
);

  localparam int SUB_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(TICK_CYCLES - 1);

  logic [SUB_W-1:0] sub_cnt;
  logic [9:0]       sec_cnt;

  // each channel keeps its own sub-second count so the delay never comes up short
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sub_cnt      <= '0;
      sec_cnt      <= '0;
      asserted_out <= 1'b0;
    end else if (!cond_in) begin
      sub_cnt      <= '0;
      sec_cnt      <= '0;
      asserted_out <= 1'b0;
    end else if (!asserted_out) begin
      if (sec_cnt >= delay_sec_in) begin
        asserted_out <= 1'b1;
      end else if (sub_cnt == SUB_LAST) begin
        sub_cnt <= '0;
        sec_cnt <= sec_cnt + 10'h001;
      end else begin
        sub_cnt <= sub_cnt + SUB_W'(1);
      end
    end
  end

  property p_no_early;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(asserted_out) |-> $past(cond_in) && ($past(sec_cnt) >= $past(delay_sec_in));
  endproperty
  a_no_early: assert property (p_no_early) else $error("output asserted before delay ran out");

  property p_release;
    @(posedge clk_in) disable iff (!reset_n_in)
      !cond_in |=> !asserted_out && (sec_cnt == 10'h000);
  endproperty
  a_release: assert property (p_release) else $error("output held or count kept after condition fell");

endmodule

// [rtl/aotu_top.sv]
module aotu_top #(
  parameter int NUM_INV     = aotu_pkg::NUM_INV,
  parameter int TICK_CYCLES = aotu_pkg::TICK_CYCLES
) (
  input  wire logic                                   clk_in,
  input  wire logic                                   reset_n_in,
  input  wire logic [7:0]                             addr_in,
  input  wire logic [31:0]                            wdata_in,
  input  wire logic                                   wr_in,
  input  wire logic                                   rd_in,
  output logic      [31:0]                            rdata_out,
  input  wire aotu_pkg::aotu_inv_report_t [NUM_INV-1:0] inv_report_in,
  input  wire logic [aotu_pkg::NUM_DI-1:0]            di_pin_in,
  output logic      [aotu_pkg::NUM_DO-1:0]            do_pin_out,
  output logic      [aotu_pkg::NUM_RLY-1:0]           relay_no_out,
  output logic                                        irq_out
);

  localparam int NCH = aotu_pkg::NUM_CH;
  localparam int NDO = aotu_pkg::NUM_DO;
  localparam int NDI = aotu_pkg::NUM_DI;

  aotu_pkg::aotu_cfg_t cfg [NCH];
  logic [NCH-1:0]      cond;
  logic [NCH-1:0]      asserted;
  logic [NCH-1:0]      asserted_q;
  logic [NCH-1:0]      irq_status;
  logic [NCH-1:0]      irq_mask;
  logic [NCH-1:0]      irq_clear;
  logic [NDI-1:0]      di_s1;
  logic [NDI-1:0]      di_s2;
  logic [NDI-1:0]      di_s3;
  logic [NDI-1:0]      di_level;

  logic any_prot;
  logic any_ovp;
  logic any_otp;
  logic any_olp;
  logic any_scp;
  logic any_running;
  logic any_off;
  logic all_disc;

  function automatic logic [9:0] delay_seconds(input logic [3:0] code);
    logic [9:0] secs;
    secs = 10'h000;
    case (code)
      aotu_pkg::DLY_IMMED: secs = 10'h000;
      aotu_pkg::DLY_1S:    secs = aotu_pkg::SEC_1;
      aotu_pkg::DLY_5S:    secs = aotu_pkg::SEC_5;
      aotu_pkg::DLY_10S:   secs = aotu_pkg::SEC_10;
      aotu_pkg::DLY_30S:   secs = aotu_pkg::SEC_30;
      default: begin
        // minute codes run 1 to 10; anything above falls back to immediate
        if (code >= aotu_pkg::DLY_1MIN && code <= aotu_pkg::DLY_10MIN) begin
          secs = 10'(({6'h00, code} - {6'h00, aotu_pkg::DLY_30S}) * aotu_pkg::SEC_PER_MIN);
        end else begin
          secs = 10'h000;
        end
      end
    endcase
    return secs;
  endfunction

  // digital inputs: three flops, a new level counts once the last two agree
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      di_s1    <= {NDI{aotu_pkg::RST_DI_LEVEL}};
      di_s2    <= {NDI{aotu_pkg::RST_DI_LEVEL}};
      di_s3    <= {NDI{aotu_pkg::RST_DI_LEVEL}};
      di_level <= {NDI{aotu_pkg::RST_DI_LEVEL}};
    end else begin
      di_s1 <= di_pin_in;
      di_s2 <= di_s1;
      di_s3 <= di_s2;
      for (int i = 0; i < NDI; i++) begin
        if (di_s2[i] == di_s3[i]) begin
          di_level[i] <= di_s3[i];
        end
      end
    end
  end

  // inverter report summaries; reports from disconnected units are ignored
  always_comb begin
    any_prot    = 1'b0;
    any_ovp     = 1'b0;
    any_otp     = 1'b0;
    any_olp     = 1'b0;
    any_scp     = 1'b0;
    any_running = 1'b0;
    any_off     = 1'b0;
    all_disc    = 1'b1;
    for (int k = 0; k < NUM_INV; k++) begin
      if (inv_report_in[k].connected) begin
        all_disc = 1'b0;
        any_ovp  = any_ovp | inv_report_in[k].over_voltage_protection;
        any_otp  = any_otp | inv_report_in[k].over_temperature_protection;
        any_olp  = any_olp | inv_report_in[k].overload_protection;
        any_scp  = any_scp | inv_report_in[k].short_circuit_protection;
        any_prot = any_prot | inv_report_in[k].over_voltage_protection
                 | inv_report_in[k].over_temperature_protection
                 | inv_report_in[k].overload_protection
                 | inv_report_in[k].short_circuit_protection
                 | inv_report_in[k].other_protection;
        any_running = any_running | inv_report_in[k].running;
        any_off  = any_off | inv_report_in[k].remote_off | inv_report_in[k].alarm;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [2:0] di_idx;
      logic [9:0] delay_sec;

      assign di_idx    = cfg[g].source - aotu_pkg::SRC_DI_BASE;
      assign delay_sec = delay_seconds(cfg[g].delay);

      // unsupported source and trigger pairs never trigger
      always_comb begin
        cond[g] = 1'b0;
        if (cfg[g].source == aotu_pkg::SRC_ALARM) begin
          case (cfg[g].trigger)
            aotu_pkg::TRG_ANY: cond[g] = any_prot;
            aotu_pkg::TRG_OVP: cond[g] = any_ovp;
            aotu_pkg::TRG_OTP: cond[g] = any_otp;
            aotu_pkg::TRG_OLP: cond[g] = any_olp;
            aotu_pkg::TRG_SCP: cond[g] = any_scp;
            default:           cond[g] = 1'b0;
          endcase
        end else if (cfg[g].source == aotu_pkg::SRC_INV) begin
          case (cfg[g].trigger)
            aotu_pkg::TRG_INV_ON:  cond[g] = any_running;
            aotu_pkg::TRG_INV_OFF: cond[g] = any_off | all_disc;
            default:               cond[g] = 1'b0;
          endcase
        end else if (cfg[g].source <= aotu_pkg::SRC_DI_LAST) begin
          case (cfg[g].trigger)
            aotu_pkg::TRG_DI_HIGH: cond[g] = di_level[di_idx];
            aotu_pkg::TRG_DI_LOW:  cond[g] = ~di_level[di_idx];
            default:               cond[g] = 1'b0;
          endcase
        end
      end

      aotu_delay_chan #(
        .TICK_CYCLES (TICK_CYCLES)
      ) u_delay (
        .clk_in       (clk_in),
        .reset_n_in   (reset_n_in),
        .cond_in      (cond[g]),
        .delay_sec_in (delay_sec),
        .asserted_out (asserted[g])
      );

      // configuration register, one word per channel
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cfg[g].source      <= aotu_pkg::RST_SOURCE;
          cfg[g].trigger     <= aotu_pkg::RST_TRIGGER;
          cfg[g].active_high <= aotu_pkg::RST_LEVEL;
          cfg[g].delay       <= aotu_pkg::RST_DELAY;
        end else if (wr_in && addr_in == aotu_pkg::ADDR_CFG_BASE + 8'(4 * g)) begin
          cfg[g].source      <= wdata_in[aotu_pkg::CFG_SRC_LSB +: 3];
          cfg[g].trigger     <= wdata_in[aotu_pkg::CFG_TRG_LSB +: 3];
          cfg[g].active_high <= wdata_in[aotu_pkg::CFG_LVL_BIT];
          cfg[g].delay       <= wdata_in[aotu_pkg::CFG_DLY_LSB +: 4];
        end
      end

      if (g < NDO) begin : g_do
        always_ff @(posedge clk_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            do_pin_out[g] <= ~aotu_pkg::RST_LEVEL;
          end else begin
            do_pin_out[g] <= asserted[g] ? cfg[g].active_high : ~cfg[g].active_high;
          end
        end
      end else begin : g_rly
        // relay has no level setting: energised coil means common on normally open
        always_ff @(posedge clk_in or negedge reset_n_in) begin
          if (!reset_n_in) begin
            relay_no_out[g-NDO] <= 1'b0;
          end else begin
            relay_no_out[g-NDO] <= asserted[g];
          end
        end
      end
    end
  endgenerate

  // interrupt: rising edge of any channel's assertion; a set beats a same-cycle clear
  assign irq_clear = (wr_in && addr_in == aotu_pkg::ADDR_IRQ_STATUS) ? wdata_in[NCH-1:0] : '0;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      asserted_q <= '0;
      irq_status <= '0;
    end else begin
      asserted_q <= asserted;
      irq_status <= (irq_status & ~irq_clear) | (asserted & ~asserted_q);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask <= aotu_pkg::RST_IRQ_MASK;
    end else if (wr_in && addr_in == aotu_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wdata_in[NCH-1:0];
    end
  end

  assign irq_out = |(irq_status & irq_mask);

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= 32'h0000_0000;
      if (rd_in) begin
        case (addr_in)
          aotu_pkg::ADDR_OUT_STATE:  rdata_out <= {{(32-NCH){1'b0}}, asserted};
          aotu_pkg::ADDR_IRQ_STATUS: rdata_out <= {{(32-NCH){1'b0}}, irq_status};
          aotu_pkg::ADDR_IRQ_MASK:   rdata_out <= {{(32-NCH){1'b0}}, irq_mask};
          aotu_pkg::ADDR_DI_LEVEL:   rdata_out <= {{(32-NDI){1'b0}}, di_level};
          default: begin
            for (int i = 0; i < NCH; i++) begin
              if (addr_in == aotu_pkg::ADDR_CFG_BASE + 8'(4 * i)) begin
                rdata_out[aotu_pkg::CFG_SRC_LSB +: 3] <= cfg[i].source;
                rdata_out[aotu_pkg::CFG_TRG_LSB +: 3] <= cfg[i].trigger;
                // relays carry no level; the bit reads zero
                rdata_out[aotu_pkg::CFG_LVL_BIT]      <= (i < NDO) ? cfg[i].active_high : 1'b0;
                rdata_out[aotu_pkg::CFG_DLY_LSB +: 4] <= cfg[i].delay;
              end
            end
          end
        endcase
      end
    end
  end

  // checks on channels 0 to 4 (digital outputs) and channels 5 and 6 (the first two relays)
  sequence s_cond_rise_immed;
    !cond[0] ##1 (cond[0] && cfg[0].delay == aotu_pkg::DLY_IMMED);
  endsequence

  sequence s_out_active;
    asserted[0] ##1 (do_pin_out[0] == $past(cfg[0].active_high));
  endsequence

  property p_immediate;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_cond_rise_immed ##1 cond[0] |-> asserted[0];
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate delay did not assert next cycle");

  property p_do_level;
    @(posedge clk_in) disable iff (!reset_n_in)
      $stable(cfg[0].active_high) |=> do_pin_out[0] == ($past(asserted[0]) ? $past(cfg[0].active_high)
                                                                          : ~$past(cfg[0].active_high));
  endproperty
  a_do_level: assert property (p_do_level) else $error("digital output level wrong");

  // the pin follows the level held when the channel asserted; a level write lands one cycle later
  property p_do_active;
    @(posedge clk_in) disable iff (!reset_n_in)
      asserted[0] |-> s_out_active;
  endproperty
  a_do_active: assert property (p_do_active) else $error("asserted digital output not at active level");

  property p_do_idle;
    @(posedge clk_in) disable iff (!reset_n_in)
      !asserted[1] |=> do_pin_out[1] != $past(cfg[1].active_high);
  endproperty
  a_do_idle: assert property (p_do_idle) else $error("idle digital output shows its active level");

  property p_relay;
    @(posedge clk_in) disable iff (!reset_n_in)
      ##1 relay_no_out[0] == $past(asserted[NDO]);
  endproperty
  a_relay: assert property (p_relay) else $error("relay contact does not follow trigger");

  property p_alarm_any;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cfg[2].source == aotu_pkg::SRC_ALARM && cfg[2].trigger == aotu_pkg::TRG_ANY)
        |-> cond[2] == any_prot;
  endproperty
  a_alarm_any: assert property (p_alarm_any) else $error("any-protection condition wrong");

  property p_inv_on;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cfg[3].source == aotu_pkg::SRC_INV && cfg[3].trigger == aotu_pkg::TRG_INV_ON)
        |-> cond[3] == any_running;
  endproperty
  a_inv_on: assert property (p_inv_on) else $error("inverter running condition wrong");

  property p_inv_off_disc;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cfg[4].source == aotu_pkg::SRC_INV && cfg[4].trigger == aotu_pkg::TRG_INV_OFF && all_disc)
        |-> cond[4];
  endproperty
  a_inv_off_disc: assert property (p_inv_off_disc) else $error("all-disconnected did not trigger");

  property p_di_low;
    @(posedge clk_in) disable iff (!reset_n_in)
      (cfg[6].source == aotu_pkg::SRC_DI_BASE && cfg[6].trigger == aotu_pkg::TRG_DI_LOW)
        |-> cond[6] == ~di_level[0];
  endproperty
  a_di_low: assert property (p_di_low) else $error("digital input low condition wrong");

  property p_irq_set;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(asserted[0]) |=> irq_status[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("assertion event lost from status");

  // a rising channel must reach status even when software clears it in that same cycle
  property p_irq_set_wins;
    @(posedge clk_in) disable iff (!reset_n_in)
      (asserted[4] && !asserted_q[4]) |=> irq_status[4];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("rising channel lost from status");

  // a written one clears the bit unless the channel rises in the same cycle
  property p_irq_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
      (irq_clear[4] && !(asserted[4] && !asserted_q[4])) |=> !irq_status[4];
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit survived its clear");

endmodule

// [dv/aotu_partner.sv]
module aotu_partner #(
  parameter int NUM_INV = 4
) (
  input  wire logic                                clk_in,
  output aotu_pkg::aotu_inv_report_t [NUM_INV-1:0] inv_report_out,
  output logic [aotu_pkg::NUM_DI-1:0]              di_pin_out
);
  timeunit 1ns;
  timeprecision 100ps;

  aotu_pkg::aotu_inv_report_t [NUM_INV-1:0] state;
  logic                                     garbage;

  initial begin
    state = '0;
    garbage = 1'b0;
    // unconnected inputs sit high through the pull-up
    di_pin_out = 5'h1F;
  end

  always @(posedge clk_in) begin
    garbage <= ~garbage;
  end

  // a disconnected unit reports nothing trustworthy: its status bits toggle
  always @* begin
    for (int i = 0; i < NUM_INV; i++) begin
      inv_report_out[i] = state[i].connected ? state[i] : {1'b0, {8{garbage}}};
    end
  end

  task automatic set_inv(input int idx, input logic [8:0] rep);
    state[idx] <= rep;
  endtask

  task automatic set_di(input logic [4:0] lvl);
    di_pin_out <= lvl;
  endtask
endmodule

// [dv/aotu_top_test.sv]
module aotu_top_test;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TICKS    = 4;
  localparam int NI       = 4;
  localparam int SECS [5] = '{0, 1, 5, 10, 30};

  logic                                clk_in = 1'b0;
  logic                                reset_n_in = 1'b0;
  logic [7:0]                          addr_in = 8'h00;
  logic [31:0]                         wdata_in = 32'h0000_0000;
  logic                                wr_in = 1'b0;
  logic                                rd_in = 1'b0;
  logic [31:0]                         rdata_out;
  aotu_pkg::aotu_inv_report_t [NI-1:0] inv_report;
  logic [4:0]                          di_pin;
  logic [4:0]                          do_pin_out;
  logic [3:0]                          relay_no_out;
  logic                                irq_out;
  logic [4:0]                          act = 5'h1F;
  int                                  error_cnt = 0;
  int                                  compares = 0;

  always #2 clk_in = ~clk_in;

  aotu_top #(.NUM_INV(NI), .TICK_CYCLES(TICKS)) aotu_top_inst (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .addr_in       (addr_in),
    .wdata_in      (wdata_in),
    .wr_in         (wr_in),
    .rd_in         (rd_in),
    .rdata_out     (rdata_out),
    .inv_report_in (inv_report),
    .di_pin_in     (di_pin),
    .do_pin_out    (do_pin_out),
    .relay_no_out  (relay_no_out),
    .irq_out       (irq_out)
  );

  aotu_partner #(.NUM_INV(NI)) aotu_partner_inst (
    .clk_in         (clk_in),
    .inv_report_out (inv_report),
    .di_pin_out     (di_pin)
  );

  task automatic stop_test();
    $display("errors %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  function automatic logic [31:0] cfg(input logic [2:0] s, input logic [2:0] t, input logic a, input logic [3:0] d);
    cfg = {16'h0000, d, 3'h0, a, 1'b0, t, 1'b0, s};
  endfunction

  task automatic set_ch(input int c, input logic [2:0] s, input logic [2:0] t, input logic a, input logic [3:0] d);
    if (c < 5) act[c] = a;
    wr(8'(4 * c), cfg(s, t, a, d));
  endtask

  // pins follow the asserted vector, digital outputs through their active level
  task automatic chk_out(input logic [8:0] asrt);
    chk({23'h0, relay_no_out, do_pin_out}, {23'h0, asrt ^ {4'h0, ~act}});
  endtask

  task automatic chk_irq(input logic e);
    #1;
    chk({31'h0, irq_out}, {31'h0, e});
  endtask

  task automatic drive(input logic v);
    @(posedge clk_in);
    aotu_partner_inst.set_di({4'h8, v});
  endtask

  task automatic t_reset();
    for (int c = 0; c < 9; c++) begin
      rd_chk(8'(4 * c), (c < 5) ? 32'h0000_0100 : 32'h0000_0000);
    end
    rd_chk(aotu_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk(8'h34, 32'h0000_0000);
    rd_chk(aotu_pkg::ADDR_DI_LEVEL, 32'h0000_001F);
    wr(8'h14, cfg(3'h0, 3'h0, 1'b1, 4'h0));
    rd_chk(8'h14, 32'h0000_0000);
    chk_out(9'h000);
  endtask

  task automatic t_alarm();
    for (int t = 0; t < 5; t++) begin
      for (int c = 0; c < 9; c++) set_ch(c, aotu_pkg::SRC_ALARM, 3'(t), 1'b1, 4'h0);
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_in);
        aotu_partner_inst.set_inv(1, 9'h100 | (9'h010 >> k));
        wait_cyc(3);
        chk_out((t == 0 || t == k + 1) ? 9'h1FF : 9'h000);
      end
      @(posedge clk_in);
      aotu_partner_inst.set_inv(1, 9'h000);
    end
  endtask

  task automatic t_inv();
    logic [8:0] rep [5];
    logic [1:0] onoff [5];
    rep = '{9'h000, 9'h180, 9'h140, 9'h120, 9'h100};
    onoff = '{2'b01, 2'b10, 2'b01, 2'b01, 2'b00};
    for (int c = 0; c < 9; c++) begin
      set_ch(c, aotu_pkg::SRC_INV, c[0] ? aotu_pkg::TRG_INV_OFF : aotu_pkg::TRG_INV_ON, c != 1 && c != 3, 4'h0);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      aotu_partner_inst.set_inv(0, rep[i]);
      wait_cyc(3);
      chk_out((onoff[i][1] ? 9'h155 : 9'h000) | (onoff[i][0] ? 9'h0AA : 9'h000));
    end
  endtask

  task automatic t_di();
    for (int i = 0; i < 5; i++) begin
      for (int c = 0; c < 9; c++) begin
        set_ch(c, 3'(aotu_pkg::SRC_DI_BASE + i), c[0] ? aotu_pkg::TRG_DI_LOW : aotu_pkg::TRG_DI_HIGH, 1'b1, 4'h0);
      end
      for (int lv = 0; lv < 2; lv++) begin
        @(posedge clk_in);
        aotu_partner_inst.set_di(lv[0] ? (5'h01 << i) : ~(5'h01 << i));
        wait_cyc(7);
        chk_out(lv[0] ? 9'h155 : 9'h0AA);
      end
    end
  endtask

  task automatic t_delay();
    int s;
    int n;
    for (int d = 0; d < 16; d++) begin
      s = (d < 5) ? SECS[d] : (d == 15) ? 0 : (d - 4) * 60;
      set_ch(4, aotu_pkg::SRC_DI_BASE, aotu_pkg::TRG_DI_HIGH, 1'b1, 4'(d));
      set_ch(8, aotu_pkg::SRC_DI_BASE, aotu_pkg::TRG_DI_HIGH, 1'b0, 4'(d));
      // a short true spell must not count toward the next one
      if (d == 2) begin
        drive(1'b1);
        wait_cyc(14);
        drive(1'b0);
        wait_cyc(2);
      end
      drive(1'b1);
      wait_cyc(5 + s * TICKS);
      chk({30'h0, relay_no_out[3], do_pin_out[4]}, 32'h0000_0000);
      n = 0;
      while ({relay_no_out[3], do_pin_out[4]} !== 2'b11 && n < s + 3) begin
        wait_cyc(1);
        n++;
      end
      chk({30'h0, relay_no_out[3], do_pin_out[4]}, 32'h0000_0003);
      if ({relay_no_out[3], do_pin_out[4]} !== 2'b11) stop_test();
      drive(1'b0);
      wait_cyc(5);
      chk({30'h0, relay_no_out[3], do_pin_out[4]}, 32'h0000_0003);
      wait_cyc(1);
      chk({30'h0, relay_no_out[3], do_pin_out[4]}, 32'h0000_0000);
    end
  endtask

  task automatic t_irq();
    wr(aotu_pkg::ADDR_IRQ_MASK, 32'h0000_0010);
    wr(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_01FF);
    rd_chk(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    chk_irq(1'b0);
    drive(1'b1);
    wait_cyc(8);
    // channels 0, 2 and 6 still watch input 4 high, which drive keeps high
    rd_chk(aotu_pkg::ADDR_OUT_STATE, 32'h0000_0155);
    wr(aotu_pkg::ADDR_OUT_STATE, 32'h0000_0000);
    rd_chk(aotu_pkg::ADDR_OUT_STATE, 32'h0000_0155);
    rd_chk(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0110);
    chk_irq(1'b1);
    wr(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0100);
    rd_chk(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0010);
    chk_irq(1'b1);
    wr(aotu_pkg::ADDR_IRQ_MASK, 32'h0000_0100);
    chk_irq(1'b0);
    wr(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0010);
    drive(1'b0);
    wait_cyc(7);
    drive(1'b1);
    wait_cyc(8);
    rd_chk(aotu_pkg::ADDR_IRQ_STATUS, 32'h0000_0110);
    chk_irq(1'b1);
    wr(aotu_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    chk_irq(1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_alarm();
    t_inv();
    t_di();
    t_delay();
    t_irq();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    error_cnt++;
    stop_test();
  end
endmodule
